/* File: hdl/sp0_pkg.sv */
/*
 * Shared constants and types for serial port zero: register addresses,
 * control/status bit positions, divider and frame figures, engine states.
 * Assumes one 100 MHz system clock and the processor's 8-bit register port.
 */
package sp0_pkg;
    // ----------------------------------------------------------------
    // Register addresses and fields
    // ----------------------------------------------------------------
    localparam logic [7:0] SERIAL_CONTROL_STATUS_ADDR = 8'h98;
    localparam logic [7:0] SERIAL_DATA_BUFFER_ADDR = 8'h99;
    localparam logic [7:0] UNMAPPED_READ = 8'hff;
    localparam int BYTE_W = 8;
    localparam int BIT_MODE_OR_FE = 7;
    localparam int BIT_MODE_HIGH = 6;
    localparam int BIT_GATING = 5;
    localparam int BIT_RX_ENABLE = 4;
    localparam int BIT_TX_NINTH = 3;
    localparam int BIT_RX_NINTH = 2;
    localparam int BIT_TX_DONE = 1;
    localparam int BIT_RX_DONE = 0;
    localparam logic [7:0] SERIAL_CONTROL_STATUS_RESET = 8'h00;

    // ----------------------------------------------------------------
    // Modes and timing
    // ----------------------------------------------------------------
    localparam logic [1:0] MODE_SYNC = 2'h0;
    localparam logic [1:0] MODE_ASYNC10 = 2'h1;
    localparam logic [1:0] MODE_ASYNC11_FIXED = 2'h2;
    localparam logic [1:0] MODE_ASYNC11_VAR = 2'h3;
    localparam logic [3:0] SYNC_DIV_SLOW = 4'hc;
    localparam logic [3:0] SYNC_DIV_FAST = 4'h4;
    localparam logic [1:0] FIXED_PRESCALE = 2'h3;
    localparam logic [1:0] FIXED_PRESCALE_DBL = 2'h1;
    localparam logic [3:0] LAST_SAMPLE = 4'hf;
    localparam logic [3:0] MID_SAMPLE = 4'h7;
    localparam logic [3:0] SYNC_LAST_BIT = 4'h7;
    localparam logic [3:0] STOP_IDX_10 = 4'h9;
    localparam logic [3:0] STOP_IDX_11 = 4'ha;
    localparam logic [3:0] NINTH_IDX = 4'h9;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_ASYNC = 2'b01,
        TX_SYNC = 2'b10
    } tx_state_t;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_ASYNC = 2'b01,
        RX_SYNC = 2'b10
    } rx_state_t;
endpackage

/* File: hdl/byte_buf_if.sv */
/*
 * Valid/ready carrier between the serial core and its transmit buffer.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
interface byte_buf_if #(parameter int WIDTH = 8);
    logic in_valid;
    logic in_ready;
    logic [WIDTH-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [WIDTH-1:0] out_data;

    modport store (
        input in_valid, in_data, out_ready,
        output in_ready, out_valid, out_data
    );
    modport user (
        output in_valid, in_data, out_ready,
        input in_ready, out_valid, out_data
    );
endinterface

/* File: hdl/byte_buf.sv */
/*
 * Small FIFO with valid/ready on both sides; ready and valid come from flops.
 * Assumes DEPTH is a power of two and at least two.
 */
`timescale 1ns/100ps
module byte_buf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    byte_buf_if.store port
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [PW:0] count;
        logic space;
        logic filled;
    } buf_state_t;

    buf_state_t s_reg;
    buf_state_t s_next;
    logic push;
    logic pop;

    assign port.in_ready = s_reg.space;
    assign port.out_valid = s_reg.filled;
    assign port.out_data = s_reg.mem[s_reg.rd_ptr];

    always_comb begin
        s_next = s_reg;
        push = port.in_valid && s_reg.space;
        pop = port.out_ready && s_reg.filled;
        if (push) begin
            s_next.mem[s_reg.wr_ptr] = port.in_data;
            s_next.wr_ptr = s_reg.wr_ptr + 1'b1;
        end
        if (pop) begin
            s_next.rd_ptr = s_reg.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            s_next.count = s_reg.count + 1'b1;
        end else if (pop && !push) begin
            s_next.count = s_reg.count - 1'b1;
        end
        s_next.space = (s_next.count != (PW+1)'(DEPTH));
        s_next.filled = (s_next.count != '0);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_reg <= '0;
            s_reg.space <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule

/* File: hdl/serial_port_zero.sv */
/*
 * Serial port zero: control/status and data buffer registers, a shift-mode
 * engine and asynchronous transmitter and receiver, with a two-entry
 * transmit buffer. Assumes a single clock, a one-cycle register port from
 * the core, baud_tick pulses from a timer for the variable-rate modes, and
 * the power control bits delivered as plain levels.
 */
//
// Function
// [R1] Mode bits pick shift or async frame format
// [R2] Bit 7 flags framing error; software clears
// [R3] Modes 2/3 gating: ninth bit 0 blocks flag
// [R4] Mode 1 gating: bad stop blocks flag
// [R5] Mode 0 gating bit picks divide 12/4
// [R6] Receive only while receive enable set
// [R7] Modes 2/3 send written ninth bit
// [R8] Ninth-bit field captures ninth or stop bit
// [R9] Transmit-done set end bit 8 / stop start
// [R10] Receive-done set end bit 8 / mid-stop
// [R11] Data address: read receive, write transmit
// [R12] Frame-error select decides bit 7 role
// [R13] Baud doubler halves bit time, modes 1-3
// [R14] Dedicated serial input and output pins
// [R15] Buffer write starts frame; mode 0 clocks out
// [R16] Async receive: start edge, centre sampling
`timescale 1ns/100ps
module serial_port_zero (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    output logic tx_buf_ready,
    input wire logic frame_error_select,
    input wire logic baud_doubler,
    input wire logic baud_tick,
    input wire logic rxd_in,
    output logic rxd_out,
    output logic rxd_oe_n,
    output logic txd
);
    typedef struct packed {
        logic mode_select_low;
        logic framing_error_flag;
        logic mode_select_high;
        logic multiproc_gating;
        logic rx_enable;
        logic tx_ninth_bit;
        logic rx_ninth_bit;
        logic tx_done_flag;
        logic rx_done_flag;
        logic [7:0] rx_data;
        logic [7:0] rdata;
        sp0_pkg::tx_state_t tx_state;
        logic [10:0] tx_shift;
        logic [3:0] tx_bit;
        logic [3:0] tx_cnt;
        sp0_pkg::rx_state_t rx_state;
        logic [8:0] rx_shift;
        logic [3:0] rx_bit;
        logic [3:0] rx_cnt;
        logic [1:0] pre_cnt;
        logic half_div;
        logic rxd_prev;
        logic txd;
        logic rxd_out;
        logic rxd_oe_n;
    } state_t;

    state_t s_reg;
    state_t s_next;
    logic [1:0] mode;
    logic bit7_is_fe;
    logic tick;
    logic [3:0] sync_div;
    logic [3:0] sync_half;
    logic [3:0] stop_idx;
    logic tx_start;
    logic accept;
    logic stop_bit;
    logic ninth;
    logic [7:0] rx_byte;
    logic [7:0] serial_control_status_view;

    byte_buf_if #(.WIDTH(sp0_pkg::BYTE_W)) tx_q ();

    byte_buf #(.WIDTH(sp0_pkg::BYTE_W), .DEPTH(2)) tx_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .port(tx_q)
    );

    assign sfr_rdata = s_reg.rdata;
    assign tx_buf_ready = tx_q.in_ready;
    assign rxd_out = s_reg.rxd_out;
    assign rxd_oe_n = s_reg.rxd_oe_n;
    assign txd = s_reg.txd;

    // A full buffer refuses the write; software watches tx_buf_ready
    assign tx_q.in_valid = sfr_wr && (sfr_addr == sp0_pkg::SERIAL_DATA_BUFFER_ADDR); // [R11]
    assign tx_q.in_data = sfr_wdata;
    assign tx_q.out_ready = tx_start;

    always_comb begin
        s_next = s_reg;
        mode = {s_reg.mode_select_low, s_reg.mode_select_high}; // [R1]
        bit7_is_fe = frame_error_select; // [R12]
        serial_control_status_view = {bit7_is_fe ? s_reg.framing_error_flag : s_reg.mode_select_low,
                     s_reg.mode_select_high, s_reg.multiproc_gating, s_reg.rx_enable,
                     s_reg.tx_ninth_bit, s_reg.rx_ninth_bit, s_reg.tx_done_flag,
                     s_reg.rx_done_flag};
        sync_div = s_reg.multiproc_gating ? sp0_pkg::SYNC_DIV_FAST
                                          : sp0_pkg::SYNC_DIV_SLOW; // [R5]
        sync_half = {1'b0, sync_div[3:1]};
        stop_idx = (mode == sp0_pkg::MODE_ASYNC10) ? sp0_pkg::STOP_IDX_10
                                                    : sp0_pkg::STOP_IDX_11; // [R1]
        tick = 1'b0;
        accept = 1'b0;
        stop_bit = rxd_in;
        ninth = s_reg.rx_shift[8];
        rx_byte = (mode == sp0_pkg::MODE_ASYNC10) ? s_reg.rx_shift[8:1] : s_reg.rx_shift[7:0];
        s_next.rxd_prev = rxd_in;

        // --------------------------------------------------------------
        // Sample tick, sixteen per bit time
        // --------------------------------------------------------------
        if (mode == sp0_pkg::MODE_ASYNC11_FIXED) begin
            // 4 clocks a sample gives 64 per bit; doubled gives 32
            if (s_reg.pre_cnt == (baud_doubler ? sp0_pkg::FIXED_PRESCALE_DBL
                                               : sp0_pkg::FIXED_PRESCALE)) begin // [R13]
                s_next.pre_cnt = '0;
                tick = 1'b1;
            end else begin
                s_next.pre_cnt = s_reg.pre_cnt + 1'b1;
            end
        end else begin
            s_next.pre_cnt = '0;
            if (baud_tick) begin
                s_next.half_div = !s_reg.half_div;
                tick = baud_doubler || s_reg.half_div; // [R13]
            end
        end

        // --------------------------------------------------------------
        // Register port; hardware sets below override these writes
        // --------------------------------------------------------------
        if (sfr_rd) begin
            if (sfr_addr == sp0_pkg::SERIAL_CONTROL_STATUS_ADDR) begin
                s_next.rdata = serial_control_status_view;
            end else if (sfr_addr == sp0_pkg::SERIAL_DATA_BUFFER_ADDR) begin
                s_next.rdata = s_reg.rx_data; // [R11]
            end else begin
                s_next.rdata = sp0_pkg::UNMAPPED_READ;
            end
        end
        if (sfr_wr && (sfr_addr == sp0_pkg::SERIAL_CONTROL_STATUS_ADDR)) begin
            if (bit7_is_fe) begin
                s_next.framing_error_flag = sfr_wdata[sp0_pkg::BIT_MODE_OR_FE]; // [R2]
            end else begin
                s_next.mode_select_low = sfr_wdata[sp0_pkg::BIT_MODE_OR_FE]; // [R12]
            end
            s_next.mode_select_high = sfr_wdata[sp0_pkg::BIT_MODE_HIGH];
            s_next.multiproc_gating = sfr_wdata[sp0_pkg::BIT_GATING];
            s_next.rx_enable = sfr_wdata[sp0_pkg::BIT_RX_ENABLE];
            s_next.tx_ninth_bit = sfr_wdata[sp0_pkg::BIT_TX_NINTH];
            s_next.rx_ninth_bit = sfr_wdata[sp0_pkg::BIT_RX_NINTH];
            s_next.tx_done_flag = sfr_wdata[sp0_pkg::BIT_TX_DONE]; // [R9]
            s_next.rx_done_flag = sfr_wdata[sp0_pkg::BIT_RX_DONE]; // [R10]
        end

        // --------------------------------------------------------------
        // Transmitter
        // --------------------------------------------------------------
        // Shift mode is half duplex on the input pin, so it waits for the receiver
        tx_start = (s_reg.tx_state == sp0_pkg::TX_IDLE) && tx_q.out_valid &&
                   ((mode != sp0_pkg::MODE_SYNC) || (s_reg.rx_state == sp0_pkg::RX_IDLE));
        case (s_reg.tx_state)
            sp0_pkg::TX_IDLE: begin
                if (tx_start && (mode == sp0_pkg::MODE_SYNC)) begin // [R15]
                    s_next.tx_state = sp0_pkg::TX_SYNC;
                    s_next.tx_shift = {3'h7, tx_q.out_data};
                    s_next.rxd_out = tx_q.out_data[0];
                    s_next.rxd_oe_n = 1'b0;
                    s_next.txd = 1'b0;
                    s_next.tx_cnt = '0;
                    s_next.tx_bit = '0;
                end else if (tx_start) begin // [R15]
                    s_next.tx_state = sp0_pkg::TX_ASYNC;
                    // Mode 1 puts its stop bit in the ninth slot; the top stop bit is never sent
                    s_next.tx_shift = {1'b1, (mode == sp0_pkg::MODE_ASYNC10) ? 1'b1
                                       : s_reg.tx_ninth_bit, tx_q.out_data, 1'b0}; // [R7]
                    s_next.txd = 1'b0;
                    s_next.tx_cnt = '0;
                    s_next.tx_bit = '0;
                end
            end
            sp0_pkg::TX_SYNC: begin
                s_next.tx_cnt = s_reg.tx_cnt + 1'b1;
                s_next.txd = (s_next.tx_cnt >= sync_half); // [R15]
                if (s_reg.tx_cnt == sync_div - 1'b1) begin
                    s_next.tx_cnt = '0;
                    s_next.txd = 1'b0;
                    s_next.tx_bit = s_reg.tx_bit + 1'b1;
                    s_next.tx_shift = {1'b1, s_reg.tx_shift[10:1]};
                    s_next.rxd_out = s_reg.tx_shift[1];
                    if (s_reg.tx_bit == sp0_pkg::SYNC_LAST_BIT) begin
                        s_next.tx_done_flag = 1'b1; // [R9]
                        s_next.tx_state = sp0_pkg::TX_IDLE;
                        s_next.txd = 1'b1;
                        s_next.rxd_oe_n = 1'b1;
                    end
                end
            end
            sp0_pkg::TX_ASYNC: begin
                if (tick) begin
                    s_next.tx_cnt = s_reg.tx_cnt + 1'b1;
                    if (s_reg.tx_cnt == sp0_pkg::LAST_SAMPLE) begin
                        s_next.tx_bit = s_reg.tx_bit + 1'b1;
                        s_next.tx_shift = {1'b1, s_reg.tx_shift[10:1]};
                        s_next.txd = s_reg.tx_shift[1]; // [R14]
                        if (s_reg.tx_bit == stop_idx - 1'b1) begin
                            s_next.tx_done_flag = 1'b1; // [R9]
                        end
                        if (s_reg.tx_bit == stop_idx) begin
                            s_next.tx_state = sp0_pkg::TX_IDLE;
                            s_next.txd = 1'b1;
                        end
                    end
                end
            end
            default: begin
                s_next.tx_state = sp0_pkg::TX_IDLE;
                s_next.txd = 1'b1;
            end
        endcase

        // --------------------------------------------------------------
        // Receiver
        // --------------------------------------------------------------
        case (s_reg.rx_state)
            sp0_pkg::RX_IDLE: begin
                if (s_reg.rx_enable && (mode == sp0_pkg::MODE_SYNC) && !s_reg.rx_done_flag &&
                    (s_reg.tx_state == sp0_pkg::TX_IDLE) && !tx_q.out_valid) begin // [R6]
                    s_next.rx_state = sp0_pkg::RX_SYNC;
                    s_next.txd = 1'b0;
                    s_next.rx_cnt = '0;
                    s_next.rx_bit = '0;
                end else if (s_reg.rx_enable && (mode != sp0_pkg::MODE_SYNC) &&
                             s_reg.rxd_prev && !rxd_in) begin // [R16]
                    s_next.rx_state = sp0_pkg::RX_ASYNC;
                    s_next.rx_cnt = '0;
                    s_next.rx_bit = '0;
                end
            end
            sp0_pkg::RX_SYNC: begin
                s_next.rx_cnt = s_reg.rx_cnt + 1'b1;
                s_next.txd = (s_next.rx_cnt >= sync_half);
                // Data is taken on the rising edge of the shift clock
                if (s_reg.rx_cnt == sync_half) begin
                    s_next.rx_shift = {rxd_in, s_reg.rx_shift[8:1]};
                end
                if (s_reg.rx_cnt == sync_div - 1'b1) begin
                    s_next.rx_cnt = '0;
                    s_next.txd = 1'b0;
                    s_next.rx_bit = s_reg.rx_bit + 1'b1;
                    if (s_reg.rx_bit == sp0_pkg::SYNC_LAST_BIT) begin
                        s_next.rx_data = s_reg.rx_shift[8:1];
                        s_next.rx_done_flag = 1'b1; // [R10]
                        s_next.rx_state = sp0_pkg::RX_IDLE;
                        s_next.txd = 1'b1;
                    end
                end
                if (!s_reg.rx_enable) begin // [R6]
                    s_next.rx_state = sp0_pkg::RX_IDLE;
                    s_next.txd = 1'b1;
                end
            end
            sp0_pkg::RX_ASYNC: begin
                if (tick) begin
                    s_next.rx_cnt = s_reg.rx_cnt + 1'b1;
                    if (s_reg.rx_cnt == sp0_pkg::LAST_SAMPLE) begin
                        s_next.rx_bit = s_reg.rx_bit + 1'b1;
                    end
                    if (s_reg.rx_cnt == sp0_pkg::MID_SAMPLE) begin // [R16]
                        if (s_reg.rx_bit == '0) begin
                            // A glitch shorter than half a bit is no start bit
                            if (rxd_in) begin
                                s_next.rx_state = sp0_pkg::RX_IDLE;
                            end
                        end else if (s_reg.rx_bit != stop_idx) begin
                            s_next.rx_shift = {rxd_in, s_reg.rx_shift[8:1]};
                        end else begin
                            s_next.rx_state = sp0_pkg::RX_IDLE;
                            if (mode == sp0_pkg::MODE_ASYNC10) begin
                                accept = !s_reg.rx_done_flag &&
                                         (!s_reg.multiproc_gating || stop_bit); // [R4]
                            end else begin
                                accept = !s_reg.rx_done_flag &&
                                         (!s_reg.multiproc_gating || ninth); // [R3]
                            end
                            if (accept) begin // [R10]
                                s_next.rx_data = rx_byte;
                                s_next.rx_ninth_bit = (mode == sp0_pkg::MODE_ASYNC10) ?
                                                      stop_bit : ninth; // [R8]
                                s_next.rx_done_flag = 1'b1;
                            end
                            if (bit7_is_fe && !stop_bit) begin
                                s_next.framing_error_flag = 1'b1; // [R2]
                            end
                        end
                    end
                end
                if (!s_reg.rx_enable) begin // [R6]
                    s_next.rx_state = sp0_pkg::RX_IDLE;
                end
            end
            default: begin
                s_next.rx_state = sp0_pkg::RX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_reg <= '0;
            s_reg.tx_state <= sp0_pkg::TX_IDLE;
            s_reg.rx_state <= sp0_pkg::RX_IDLE;
            s_reg.rdata <= sp0_pkg::SERIAL_CONTROL_STATUS_RESET;
            s_reg.rxd_prev <= 1'b1;
            s_reg.txd <= 1'b1;
            s_reg.rxd_out <= 1'b1;
            s_reg.rxd_oe_n <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule

/* File: tb/serial_port_zero_sva.sv */
/* Port checks for serial port zero: register port answers, pin idle
   levels, shift-mode pin timing. Assumes a bind to the top module. */
`timescale 1ns/100ps
module serial_port_zero_sva (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_rdata,
    input wire logic tx_buf_ready,
    input wire logic rxd_out,
    input wire logic rxd_oe_n,
    input wire logic txd
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_reset_idle; $rose(rst_n) |-> txd && rxd_oe_n && sfr_rdata == 8'h00; endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("pins not idle after reset");
    property p_rd_unmapped; sfr_rd && sfr_addr < 8'h98 |=> sfr_rdata == 8'hff; endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read wrong");
    property p_rdata_hold; !sfr_rd |=> $stable(sfr_rdata); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_ready_fall; $fell(tx_buf_ready) |-> $past(sfr_wr && sfr_addr == 8'h99); endproperty
    a_ready_fall: assert property (p_ready_fall) else $error("buffer full without write");
    // Start bit of an async frame lasts at least half the shortest bit
    property p_start_len; $fell(txd) && rxd_oe_n |-> !txd [*8]; endproperty
    a_start_len: assert property (p_start_len) else $error("start bit too short");
    property p_oe_fall; $fell(rxd_oe_n) |-> !txd; endproperty
    a_oe_fall: assert property (p_oe_fall) else $error("shift clock not low at start");
    property p_oe_len; $fell(rxd_oe_n) |-> !rxd_oe_n [*8]; endproperty
    a_oe_len: assert property (p_oe_len) else $error("shift frame too short");
    // Low half is 2 or 6 clocks, so high again within 6
    property p_shift_half; $fell(txd) && !rxd_oe_n |=> !txd ##[1:5] txd; endproperty
    a_shift_half: assert property (p_shift_half) else $error("shift clock half wrong");
    property p_data_edge; !rxd_oe_n && $changed(rxd_out) |-> !txd; endproperty
    a_data_edge: assert property (p_data_edge) else $error("data moved while clock high");
    c_shift: cover property ($fell(rxd_oe_n));
    c_full: cover property ($fell(tx_buf_ready));
    c_rd_data: cover property (sfr_rd && sfr_addr == 8'h99);
endmodule

/* File: tb/far_serial.sv */
/* Far serial node: sends frames on the receive pin, samples frames on
   the transmit pin. Assumes the bench calls its tasks. */
`timescale 1ns/100ps
module far_serial (
    input wire logic clk,
    input wire logic txd,
    output logic rxd_in
);
    initial rxd_in = 1'b1;
    // Bits go out LSB first, len clocks each, then the line idles at mark
    task automatic send(input logic [10:0] bits, input int n, input int len);
        for (int i = 0; i < n; i++) begin
            rxd_in <= bits[i];
            repeat (len) @(posedge clk);
        end
        rxd_in <= 1'b1;
    endtask
    // Returns at the stop centre so a following start edge is not missed
    task automatic grab(input int len, output logic [10:0] bits);
        @(negedge txd);
        repeat (len / 2) @(negedge clk);
        for (int i = 0; i < 11; i++) begin
            bits[i] = txd;
            if (i < 10) repeat (len) @(negedge clk);
        end
    endtask
endmodule

/* File: tb/serial_port_zero_bench.sv */
/* Bench for serial port zero: receive frames, transmit frames, buffer
   refusal, shift mode, reset. Assumes far_serial and the checker. */
`timescale 1ns/100ps
module serial_port_zero_bench;
    typedef struct packed {
        logic [7:0] ctl;
        logic [7:0] data;
        logic ninth;
        logic [7:0] exp;
        logic [7:0] mask;
    } row_t;
    // Control written, byte and ninth/stop sent, control expected
    row_t rows [8] = '{
        '{8'h90, 8'ha5, 1'b1, 8'h95, 8'hff}, '{8'hb0, 8'h3c, 1'b0, 8'hb0, 8'hfb},
        '{8'hb0, 8'h5a, 1'b1, 8'hb5, 8'hff}, '{8'hd0, 8'h81, 1'b0, 8'hd1, 8'hff},
        '{8'h50, 8'h7e, 1'b1, 8'h55, 8'hff}, '{8'h70, 8'h42, 1'b0, 8'h70, 8'hfb},
        '{8'h80, 8'h11, 1'b1, 8'h80, 8'hfb}, '{8'h50, 8'hc3, 1'b0, 8'h51, 8'hff}};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic sfr_rd = 1'b0;
    logic frame_error_select = 1'b0;
    logic baud_doubler = 1'b0;
    logic [7:0] sfr_rdata, last;
    logic tx_buf_ready, rxd_in, rxd_out, rxd_oe_n, txd;
    logic [10:0] seen, fr;
    logic acc [4];
    time t0, t1;
    int miscompares = 0;
    int n_checks = 0;
    int cycles = 0;
    int k;
    // Tick every clock: variable-rate bits last 32 clocks
    serial_port_zero u_dut (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
        .tx_buf_ready(tx_buf_ready), .frame_error_select(frame_error_select),
        .baud_doubler(baud_doubler), .baud_tick(1'b1), .rxd_in(rxd_in),
        .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n), .txd(txd));
    far_serial u_far (.clk(clk), .txd(txd), .rxd_in(rxd_in));
    always #5 clk = ~clk;
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [10:0] got, input logic [10:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        @(negedge clk);
        seen = {3'h0, sfr_rdata};
        @(posedge clk);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            wrap_up();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            wr(8'h98, rows[i].ctl);
            u_far.send({1'b1, rows[i].ninth, rows[i].data, 1'b0}, rows[i].ctl[7:6] == 2'h1 ? 10 : 11,
                rows[i].ctl[7:6] == 2'h2 ? 64 : 32);
            rd(8'h98);
            check("control", seen & {3'h0, rows[i].mask}, {3'h0, rows[i].exp & rows[i].mask});
            if (rows[i].exp[0]) last = rows[i].data;
            rd(8'h99);
            check("rx data", seen, {3'h0, last});
        end
        // Framing error replaces mode bit 0 only while selected
        wr(8'h98, 8'h50);
        frame_error_select <= 1'b1;
        u_far.send(11'h400, 10, 32);
        rd(8'h98);
        check("frame error", seen, 11'h0d1);
        wr(8'h98, 8'h50);
        rd(8'h98);
        check("error clear", seen, 11'h050);
        frame_error_select <= 1'b0;
        wr(8'h98, 8'h88);
        fork
            wr(8'h99, 8'h3c);
            u_far.grab(64, fr);
        join
        @(posedge clk);
        check("tx frame", fr, {2'b11, 8'h3c, 1'b0});
        rd(8'h98);
        check("tx done", seen, 11'h08a);
        baud_doubler <= 1'b1;
        wr(8'h98, 8'h88);
        fork
            begin
                for (int i = 0; i < 4; i++) begin
                    sfr_addr <= 8'h99;
                    sfr_wdata <= 8'h10 + 8'(i);
                    sfr_wr <= 1'b1;
                    @(negedge clk);
                    acc[i] = tx_buf_ready;
                    @(posedge clk);
                end
                sfr_wr <= 1'b0;
            end
            u_far.grab(32, fr);
        join
        k = 0;
        for (int i = 0; i < 4; i++) begin
            if (acc[i]) begin
                if (k > 0) u_far.grab(32, fr);
                check("burst", fr, {2'b11, 8'h10 + 8'(i), 1'b0});
                k++;
            end
        end
        check("refused", {10'h0, acc[3]}, 11'h000);
        @(posedge clk);
        for (int g = 0; g < 2; g++) begin
            wr(8'h98, g ? 8'h20 : 8'h00);
            fork
                wr(8'h99, 8'h96);
                for (int b = 0; b < 8; b++) begin
                    @(posedge txd);
                    fr[b] = rxd_out;
                    if (b == 0) t0 = $time;
                    if (b == 1) t1 = $time;
                end
            join
            repeat (8) @(posedge clk);
            check("shift data", {3'h0, fr[7:0]}, 11'h096);
            check("shift period", 11'((t1 - t0) / 10), g ? 11'h004 : 11'h00c);
            rd(8'h98);
            check("shift done", seen, g ? 11'h022 : 11'h002);
        end
        // Second reset in mid-run
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h98);
        check("reset", seen, 11'h000);
        check("pins", {8'h0, txd, rxd_oe_n, tx_buf_ready}, 11'h007);
        rd(8'h97);
        check("unmapped", seen, 11'h0ff);
        wrap_up();
    end
endmodule
bind serial_port_zero serial_port_zero_sva u_sva (.clk(clk), .rst_n(rst_n),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .tx_buf_ready(tx_buf_ready), .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n), .txd(txd));
